//--- core/isad_consts.svh
`ifndef ISAD_CONSTS_SVH
`define ISAD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ISAD_OFF_CTRL 8'h00
`define ISAD_OFF_PPR 8'h04
`define ISAD_OFF_MAX_RPM 8'h08
`define ISAD_OFF_CMD 8'h0C
`define ISAD_OFF_STATUS 8'h10
`define ISAD_OFF_ANGLE 8'h14
`define ISAD_OFF_ANGLE_END 8'h18
`define ISAD_OFF_SPEED 8'h1C
`define ISAD_OFF_IRQ_STAT 8'h20
`define ISAD_OFF_IRQ_MASK 8'h24

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ISAD_CMD_MAN_RESET 0
`define ISAD_ST_OVERSPEED 0
`define ISAD_ST_DIR 1
`define ISAD_ST_QUAD 2
`define ISAD_ST_INDEX 3
`define ISAD_ST_RES_LSB 4
`define ISAD_IRQ_OVERSPEED 0
`define ISAD_IRQ_INDEX 1
`define ISAD_IRQ_WRAP 2
`define ISAD_IRQ_DIR 3
`define ISAD_IRQ_W 4

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define ISAD_CTRL_W 13
`define ISAD_CTRL_RST 13'h0001
`define ISAD_PPR_RST 13'h0400
`define ISAD_PPR_MIN 13'h0001
`define ISAD_PPR_MAX 13'h1388
`define ISAD_RPM_RST 16'h4E20
`define ISAD_RPM_MIN 16'h0001
`define ISAD_RPM_MAX 16'hC350
`define ISAD_OVR_NUM 105
`define ISAD_OVR_DEN 100

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ISAD_CLK_HZ 10000000
`define ISAD_CLK_NS 100
`define ISAD_GF_82_NS 82
`define ISAD_GF_1US_NS 1000
`define ISAD_GF_10US_NS 10000
`define ISAD_GF_100US_NS 100000
`define ISAD_CYC_UP(ns) (((ns) + `ISAD_CLK_NS - 1) / `ISAD_CLK_NS)
`define ISAD_GF_82_CYC `ISAD_CYC_UP(`ISAD_GF_82_NS)
`define ISAD_GF_1US_CYC `ISAD_CYC_UP(`ISAD_GF_1US_NS)
`define ISAD_GF_10US_CYC `ISAD_CYC_UP(`ISAD_GF_10US_NS)
`define ISAD_GF_100US_CYC `ISAD_CYC_UP(`ISAD_GF_100US_NS)
`define ISAD_SAMPLE_NS 100000
`define ISAD_SAMPLE_CYC (`ISAD_SAMPLE_NS / `ISAD_CLK_NS)
`define ISAD_GATE_NS 100000000
`define ISAD_GATE_CYC (`ISAD_GATE_NS / `ISAD_CLK_NS)

`endif

//--- core/isad_decoder.sv
// Function
// - Source selects manual or transducer settings.
// - Manual pulses per revolution 1 to 5000.
// - Manual maximum speed 1 to 50000 rpm.
// - Over-speed flag above maximum plus 5 percent.
// - Quadrature tracks give rotation direction.
// - Manual setting says index pulse present.
// - Resolution 1x, 2x, 4x edge selection.
// - 4x refused for single-track type.
// - Angle wraps to zero at 360/720.
// - Quadrature counts up or down.
// - Interpolate angle between edges when enabled.
// - Glitch filter ignores edges within hold-off.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "isad_consts.svh"
module isad_decoder
  import isad_pkg::*;
#(
  parameter int unsigned GATE_CYC = `ISAD_GATE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic speed_track_a_i,
  input wire logic speed_track_b_i,
  input wire logic zero_index_i,
  input wire logic fb_angle_reset_i,
  input wire logic [12:0] xdcr_ppr_i,
  input wire logic [15:0] xdcr_max_rpm_i,
  input wire logic xdcr_quad_i,
  input wire logic xdcr_index_present_i,
  output logic irq_o,
  output logic overspeed_o,
  output logic direction_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  isad_ctrl_t ctrl_q;
  isad_ctrl_t ctrl_wr;
  logic [12:0] ppr_q;
  logic [15:0] max_rpm_q;
  logic [`ISAD_IRQ_W-1:0] irq_stat_q;
  logic [`ISAD_IRQ_W-1:0] irq_mask_q;
  logic [`ISAD_IRQ_W-1:0] irq_evt;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic man_reset;
  logic [31:0] rd_mux;
  logic eff_quad;
  logic eff_index;
  logic [12:0] eff_ppr;
  logic [15:0] eff_rpm;
  isad_res_t eff_res;
  logic [9:0] holdoff;
  isad_edge_t trk_a;
  isad_edge_t trk_b;
  isad_edge_t idx;
  logic step;
  logic step_fwd;
  logic [15:0] angle_end;
  logic [15:0] angle_q;
  logic dir_q;
  logic angle_reset;
  logic wrapped;
  logic [15:0] age_q;
  logic [15:0] period_q;
  logic [9:0] sample_q;
  isad_div_st_t div_st_q;
  logic [3:0] div_cnt_q;
  logic [16:0] div_rem_q;
  logic [7:0] div_quo_q;
  logic [7:0] frac_q;
  logic [16:0] rem_sh;
  logic [31:0] gate_q;
  logic [23:0] pulse_q;
  logic [23:0] speed_q;
  logic ovr_q;
  logic ovr_now;
  logic dir_prev_q;

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Access phase takes two cycles: pready rises one edge after penable.
  assign wr_en = psel_i & penable_i & pready_q & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pready_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      `ISAD_OFF_CTRL: rd_mux = {19'h00000, ctrl_q};
      `ISAD_OFF_PPR: rd_mux = {19'h00000, ppr_q};
      `ISAD_OFF_MAX_RPM: rd_mux = {16'h0000, max_rpm_q};
      `ISAD_OFF_CMD: rd_mux = 32'h0000_0000;
      `ISAD_OFF_STATUS: rd_mux = {26'h0000000, eff_res, eff_index, eff_quad, dir_q, ovr_q};
      `ISAD_OFF_ANGLE: rd_mux = {8'h00, frac_q, angle_q};
      `ISAD_OFF_ANGLE_END: rd_mux = {16'h0000, angle_end};
      `ISAD_OFF_SPEED: rd_mux = {8'h00, speed_q};
      `ISAD_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
      `ISAD_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= rd_en;
      pslverr_q <= rd_en & ~addr_ok;
      if (rd_en && !pwrite_i) begin
        prdata_q <= rd_mux;
      end else if (pready_q) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // A write that asks for an illegal mode keeps the old field.
  always_comb begin
    ctrl_wr = isad_ctrl_t'(pwdata_i[`ISAD_CTRL_W-1:0]);
    if (pwdata_i[4:3] == 2'h3 ||
        (ctrl_wr.res == RES_4X && !(ctrl_wr.src_xdcr ? xdcr_quad_i : ctrl_wr.quad))) begin
      ctrl_wr.res = ctrl_q.res;
    end
    if (pwdata_i[6:5] == 2'h3) begin
      ctrl_wr.rst_src = ctrl_q.rst_src;
    end
    if (pwdata_i[11:9] > 3'h4) begin
      ctrl_wr.glitch = ctrl_q.glitch;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl_q <= isad_ctrl_t'(`ISAD_CTRL_RST);
      ppr_q <= `ISAD_PPR_RST;
      max_rpm_q <= `ISAD_RPM_RST;
    end else if (wr_en) begin
      if (paddr_i == `ISAD_OFF_CTRL) begin
        ctrl_q <= ctrl_wr;
      end
      if (paddr_i == `ISAD_OFF_PPR && pwdata_i[31:13] == 19'h00000 &&
          pwdata_i[12:0] >= `ISAD_PPR_MIN && pwdata_i[12:0] <= `ISAD_PPR_MAX) begin
        ppr_q <= pwdata_i[12:0];
      end
      if (paddr_i == `ISAD_OFF_MAX_RPM && pwdata_i[31:16] == 16'h0000 &&
          pwdata_i[15:0] >= `ISAD_RPM_MIN && pwdata_i[15:0] <= `ISAD_RPM_MAX) begin
        max_rpm_q <= pwdata_i[15:0];
      end
    end
  end

  assign man_reset = wr_en && paddr_i == `ISAD_OFF_CMD && pwdata_i[`ISAD_CMD_MAN_RESET];

  // --------------------------------------------------------------------------
  // Effective settings
  // --------------------------------------------------------------------------
  assign eff_quad = ctrl_q.src_xdcr ? xdcr_quad_i : ctrl_q.quad;
  assign eff_index = ctrl_q.src_xdcr ? xdcr_index_present_i : ctrl_q.index_present;
  assign eff_ppr = ctrl_q.src_xdcr ? xdcr_ppr_i : ppr_q;
  assign eff_rpm = ctrl_q.src_xdcr ? xdcr_max_rpm_i : max_rpm_q;
  assign eff_res = (ctrl_q.res == RES_4X && !eff_quad) ? RES_2X : ctrl_q.res;

  always_comb begin
    unique case (ctrl_q.glitch)
      GF_OFF: holdoff = 10'h000;
      GF_82NS: holdoff = 10'(`ISAD_GF_82_CYC);
      GF_1US: holdoff = 10'(`ISAD_GF_1US_CYC);
      GF_10US: holdoff = 10'(`ISAD_GF_10US_CYC);
      GF_100US: holdoff = 10'(`ISAD_GF_100US_CYC);
      default: holdoff = 10'h000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Input conditioning
  // --------------------------------------------------------------------------
  isad_track_filter u_filt_a (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pin_i(speed_track_a_i),
    .holdoff_i(holdoff),
    .edge_o(trk_a)
  );

  isad_track_filter u_filt_b (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pin_i(speed_track_b_i),
    .holdoff_i(holdoff),
    .edge_o(trk_b)
  );

  isad_track_filter u_filt_idx (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pin_i(zero_index_i),
    .holdoff_i(holdoff),
    .edge_o(idx)
  );

  // --------------------------------------------------------------------------
  // Edge selection and direction
  // --------------------------------------------------------------------------
  // Track B leading A is the forward direction; invert_dir swaps the sense.
  always_comb begin
    unique case (eff_res)
      RES_1X: step = trk_a.rise;
      RES_2X: step = trk_a.rise | trk_a.fall;
      RES_4X: step = trk_a.rise | trk_a.fall | trk_b.rise | trk_b.fall;
      default: step = 1'b0;
    endcase
    if (!eff_quad) begin
      step_fwd = 1'b1;
    end else if (trk_a.rise | trk_a.fall) begin
      step_fwd = (trk_b.level == trk_a.rise) ^ ctrl_q.invert_dir;
    end else begin
      step_fwd = (trk_a.level != trk_b.rise) ^ ctrl_q.invert_dir;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dir_q <= 1'b0;
    end else if (!eff_quad) begin
      dir_q <= 1'b0;
    end else if (trk_a.rise | trk_a.fall | trk_b.rise | trk_b.fall) begin
      dir_q <= ~step_fwd;
    end
  end

  // --------------------------------------------------------------------------
  // Angle counter
  // --------------------------------------------------------------------------
  assign angle_end = 16'((eff_res == RES_4X ? 18'(eff_ppr) << 2 :
                          eff_res == RES_2X ? 18'(eff_ppr) << 1 : 18'(eff_ppr))
                         << (ctrl_q.angle_720 ? 1 : 0));
  always_comb begin
    unique case (ctrl_q.rst_src)
      RST_FIELDBUS: angle_reset = fb_angle_reset_i;
      RST_MANUAL: angle_reset = man_reset;
      RST_INDEX: angle_reset = eff_index & idx.rise;
      default: angle_reset = 1'b0;
    endcase
  end
  assign wrapped = step && (step_fwd ? angle_q + 16'h0001 >= angle_end : angle_q == 16'h0000);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      angle_q <= 16'h0000;
    end else if (angle_reset) begin
      angle_q <= 16'h0000;
    end else if (step && step_fwd) begin
      angle_q <= wrapped ? 16'h0000 : angle_q + 16'h0001;
    end else if (step) begin
      angle_q <= wrapped ? angle_end - 16'h0001 : angle_q - 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Interpolation
  // --------------------------------------------------------------------------
  // At each sample instant the time since the last step is divided by the last
  // step period, giving an 8-bit fraction of one count.
  assign rem_sh = {div_rem_q[15:0], 1'b0};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || step) begin
      age_q <= 16'h0000;
    end else if (age_q != 16'hFFFF) begin
      age_q <= age_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      period_q <= 16'hFFFF;
    end else if (step) begin
      period_q <= (age_q == 16'hFFFF) ? age_q : age_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || sample_q == 10'(`ISAD_SAMPLE_CYC - 1)) begin
      sample_q <= 10'h000;
    end else begin
      sample_q <= sample_q + 10'h001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_st_q <= DIV_IDLE;
      div_cnt_q <= 4'h0;
      div_rem_q <= 17'h00000;
      div_quo_q <= 8'h00;
      frac_q <= 8'h00;
    end else begin
      unique case (div_st_q)
        DIV_IDLE: begin
          if (!ctrl_q.interp || angle_reset) begin
            frac_q <= 8'h00;
          end else if (sample_q == 10'h000) begin
            if (age_q >= period_q) begin
              frac_q <= 8'hFF;
            end else begin
              div_rem_q <= {1'b0, age_q};
              div_quo_q <= 8'h00;
              div_cnt_q <= 4'h0;
              div_st_q <= DIV_RUN;
            end
          end
        end
        DIV_RUN: begin
          if (rem_sh >= {1'b0, period_q}) begin
            div_rem_q <= rem_sh - {1'b0, period_q};
            div_quo_q <= {div_quo_q[6:0], 1'b1};
          end else begin
            div_rem_q <= rem_sh;
            div_quo_q <= {div_quo_q[6:0], 1'b0};
          end
          div_cnt_q <= div_cnt_q + 4'h1;
          if (div_cnt_q == 4'h7) begin
            frac_q <= {div_quo_q[6:0], rem_sh >= {1'b0, period_q}};
            div_st_q <= DIV_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Speed and over-speed
  // --------------------------------------------------------------------------
  // Over-speed when pulses*60*f_clk*100 > rpm_max*105*ppr*gate.
  assign ovr_now = 64'(pulse_q) * 64'(60) * 64'(`ISAD_CLK_HZ) * 64'(`ISAD_OVR_DEN) >
                   64'(eff_rpm) * 64'(`ISAD_OVR_NUM) * 64'(eff_ppr) * 64'(GATE_CYC);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gate_q <= 32'h0000_0000;
      pulse_q <= 24'h000000;
      speed_q <= 24'h000000;
      ovr_q <= 1'b0;
    end else if (gate_q == 32'(GATE_CYC - 1)) begin
      gate_q <= 32'h0000_0000;
      pulse_q <= 24'(trk_a.rise);
      speed_q <= pulse_q;
      ovr_q <= ovr_now;
    end else begin
      gate_q <= gate_q + 32'h0000_0001;
      if (trk_a.rise && pulse_q != 24'hFFFFFF) begin
        pulse_q <= pulse_q + 24'h000001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts and outputs
  // --------------------------------------------------------------------------
  assign irq_evt = {dir_prev_q != dir_q, wrapped & ~angle_reset, eff_index & idx.rise,
                    ovr_now & ~ovr_q & gate_q == 32'(GATE_CYC - 1)};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      dir_prev_q <= 1'b0;
      irq_q <= 1'b0;
      overspeed_o <= 1'b0;
      direction_o <= 1'b0;
    end else begin
      dir_prev_q <= dir_q;
      if (wr_en && paddr_i == `ISAD_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata_i[`ISAD_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      if (wr_en && paddr_i == `ISAD_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata_i[`ISAD_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
      overspeed_o <= ovr_q;
      direction_o <= dir_q;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_q;

endmodule : isad_decoder

//--- core/isad_pkg.sv
package isad_pkg;

  typedef enum logic [1:0] {RES_1X, RES_2X, RES_4X} isad_res_t;
  typedef enum logic [1:0] {RST_FIELDBUS, RST_MANUAL, RST_INDEX} isad_rst_src_t;
  typedef enum logic [2:0] {GF_OFF, GF_82NS, GF_1US, GF_10US, GF_100US} isad_glitch_t;
  typedef enum logic {DIV_IDLE, DIV_RUN} isad_div_st_t;

  typedef struct packed {
    logic invert_dir;
    isad_glitch_t glitch;
    logic interp;
    logic angle_720;
    isad_rst_src_t rst_src;
    isad_res_t res;
    logic index_present;
    logic quad;
    logic src_xdcr;
  } isad_ctrl_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } isad_edge_t;

endpackage : isad_pkg

//--- core/isad_track_filter.sv
`timescale 1ns/1ps
`include "isad_consts.svh"
module isad_track_filter
  import isad_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  input wire logic [9:0] holdoff_i,
  output isad_edge_t edge_o
);

  logic meta_q;
  logic sync_q;
  logic level_q;
  logic rise_q;
  logic fall_q;
  logic [9:0] hold_q;
  logic [1:0] prime_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // Hold-off filter
  // --------------------------------------------------------------------------
  // After an accepted edge, further changes are ignored until the hold-off ends.
  // Until the synchroniser holds a real pin value, the level follows it with no
  // edge flagged, so a pin that is high across reset gives no false edge.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      hold_q <= 10'h000;
      prime_q <= 2'h0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (prime_q != 2'h3) begin
        prime_q <= prime_q + 2'h1;
        level_q <= sync_q;
      end else if (hold_q != 10'h000) begin
        hold_q <= hold_q - 10'h001;
      end else if (sync_q != level_q) begin
        level_q <= sync_q;
        rise_q <= sync_q;
        fall_q <= ~sync_q;
        hold_q <= holdoff_i;
      end
    end
  end

  assign edge_o = '{level: level_q, rise: rise_q, fall: fall_q};

endmodule : isad_track_filter

//--- verification/isad_decoder_asserts.sv
`timescale 1ns/1ps
module isad_decoder_asserts #(
  parameter int unsigned GATE_CYC = 1000
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic speed_track_a_i,
  input wire logic speed_track_b_i,
  input wire logic overspeed_o,
  input wire logic direction_o
);
  // ---------------------------------------------------------------
  // Cycles since the last track, track A and bus activity
  // ---------------------------------------------------------------
  logic [7:0] trk_age_q;
  logic [7:0] bus_age_q;
  logic [31:0] a_age_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || $changed(speed_track_a_i) || $changed(speed_track_b_i)) begin
      trk_age_q <= 8'h00;
    end else if (trk_age_q != 8'hFF) begin
      trk_age_q <= trk_age_q + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || psel_i) begin
      bus_age_q <= 8'h00;
    end else if (bus_age_q != 8'hFF) begin
      bus_age_q <= bus_age_q + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || $changed(speed_track_a_i)) begin
      a_age_q <= 32'h0;
    end else if (a_age_q != 32'hFFFF_FFFF) begin
      a_age_q <= a_age_q + 32'h1;
    end
  end
  a_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside ready");
  a_dir_late: assert property ($changed(direction_o) && bus_age_q > 8'h08 |-> trk_age_q >= 8'h02)
    else $error("direction moved before synchroniser");
  a_dir_cause: assert property ($changed(direction_o) |-> trk_age_q <= 8'h07 || bus_age_q <= 8'h08)
    else $error("direction moved without track edge");
  a_ovr_cause: assert property ($rose(overspeed_o) |-> a_age_q < 2 * GATE_CYC + 16)
    else $error("over-speed without pulses");
  a_ovr_stale: assert property (a_age_q > 2 * GATE_CYC + 16 |-> !overspeed_o)
    else $error("over-speed kept without pulses");
  c_ovr: cover property ($rose(overspeed_o));
  c_err: cover property (pslverr_o);
  c_dir: cover property ($rose(direction_o));
endmodule : isad_decoder_asserts

//--- verification/isad_decoder_tb.sv
`timescale 1ns/1ps
module isad_decoder_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic er;} isad_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy, err, irq, ovr, dir, trk_a, trk_b, idx;
  logic fb = 1'b0;
  logic xq = 1'b1;
  logic xip = 1'b1;
  logic run = 1'b0;
  logic rev = 1'b0;
  logic [15:0] per = 16'h0006;
  logic [31:0] q;
  logic e;
  int enc_pos;
  int miscompares = 0;
  int total_checks = 0;
  isad_row_t rows[18] = '{
    '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'hC, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h400, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h4E20, 1'b0},
    '{1'b0, 8'h24, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h28, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'h1389, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h400, 1'b0}, '{1'b1, 8'h04, 32'h1388, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h1388, 1'b0}, '{1'b1, 8'h08, 32'hC351, 32'h0, 1'b0},
    '{1'b1, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h4E20, 1'b0},
    '{1'b1, 8'h08, 32'hC350, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'hC350, 1'b0},
    '{1'b1, 8'h04, 32'h4, 32'h0, 1'b0}, '{1'b1, 8'h2C, 32'h0, 32'h0, 1'b1}};
  always #50 sys_clk = ~sys_clk;
  isad_decoder #(.GATE_CYC(1000)) isad_decoder_i (
    .sys_clk_i(sys_clk), .reset_i(reset), .paddr_i(pa), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .speed_track_a_i(trk_a),
    .speed_track_b_i(trk_b), .zero_index_i(idx), .fb_angle_reset_i(fb), .xdcr_ppr_i(13'h0400),
    .xdcr_max_rpm_i(16'hC350), .xdcr_quad_i(xq), .xdcr_index_present_i(xip), .irq_o(irq),
    .overspeed_o(ovr), .direction_o(dir));
  isad_enc_model #(.PPR(4)) isad_enc_model_i (.sys_clk_i(sys_clk), .run_i(run), .rev_i(rev),
    .period_i(per), .track_a_o(trk_a), .track_b_o(trk_b), .index_o(idx), .pos_o(enc_pos));
  // ---------------------------------------------------------------
  // Bus, encoder and checking tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge sys_clk);
    pen <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic move(input int n, input logic r, input logic [15:0] p);
    rev <= r;
    per <= p;
    run <= 1'b1;
    repeat (n * p) @(posedge sys_clk);
    run <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : move
  task automatic end_of_test();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].x);
      chk({31'h0, e}, {31'h0, rows[i].er});
    end
    for (int g = 0; g < 6; g++) begin
      apb(1'b1, 8'h00, 32'h36 | (g << 9));
      rd(8'h00, 32'h36 | ((g > 4 ? 4 : g) << 9));
    end
    apb(1'b1, 8'h00, 32'h36);
    apb(1'b1, 8'h0C, 32'h1);
    move(18, 1'b0, 16'h0006);
    rd(8'h14, 32'h2);
    chk({31'h0, dir}, 32'h0);
    move(5, 1'b1, 16'h0006);
    rd(8'h14, 32'hD);
    chk({31'h0, dir}, 32'h1);
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, 8'h00, 32'h26 | (r << 3));
      apb(1'b1, 8'h0C, 32'h1);
      move(8, 1'b0, 16'h0006);
      rd(8'h14, 32'h2 << r);
    end
    apb(1'b1, 8'h00, 32'h16);
    fb <= 1'b1;
    @(posedge sys_clk);
    fb <= 1'b0;
    move(3, 1'b0, 16'h0006);
    apb(1'b1, 8'h0C, 32'h1);
    rd(8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'h56);
    move(20, 1'b0, 16'h0006);
    rd(8'h14, (enc_pos + 14) % 16);
    apb(1'b1, 8'h00, 32'h2E);
    apb(1'b1, 8'h00, 32'hB4);
    repeat (2100) @(posedge sys_clk);
    rd(8'h10, 32'h18);
    rd(8'h18, 32'h10);
    apb(1'b1, 8'h00, 32'h1136);
    per <= 16'h012D;
    run <= 1'b1;
    repeat (3000) @(posedge sys_clk);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, q[23:16] != 8'h00}, 32'h1);
    chk({31'h0, dir}, 32'h1);
    run <= 1'b0;
    repeat (2100) @(posedge sys_clk);
    apb(1'b1, 8'h20, 32'hF);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h3E8);
    apb(1'b1, 8'h08, 32'h477);
    per <= 16'h007D;
    run <= 1'b1;
    repeat (3000) @(posedge sys_clk);
    chk({31'h0, ovr}, 32'h0);
    apb(1'b1, 8'h08, 32'h476);
    repeat (2500) @(posedge sys_clk);
    chk({31'h0, ovr}, 32'h1);
    rd(8'h1C, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h24, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h20, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    run <= 1'b0;
    @(posedge sys_clk);
    chk({29'h0, ovr, dir, irq}, 32'h0);
    rd(8'h04, 32'h400);
    xq <= 1'b0;
    xip <= 1'b0;
    rd(8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h11);
    rd(8'h00, 32'h1);
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end
endmodule : isad_decoder_tb
bind isad_decoder isad_decoder_asserts #(.GATE_CYC(GATE_CYC)) isad_decoder_asserts_i (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .speed_track_a_i(speed_track_a_i),
  .speed_track_b_i(speed_track_b_i), .overspeed_o(overspeed_o), .direction_o(direction_o));

//--- verification/isad_enc_model.sv
`timescale 1ns/1ps
module isad_enc_model #(
  parameter int PPR = 4
) (
  input wire logic sys_clk_i,
  input wire logic run_i,
  input wire logic rev_i,
  input wire logic [15:0] period_i,
  output logic track_a_o,
  output logic track_b_o,
  output logic index_o,
  output int pos_o
);
  int cnt_q = 0;
  int pos_q = 0;
  // Position counts quarter cycles; one step each period while running.
  always @(posedge sys_clk_i) begin
    cnt_q <= (run_i && cnt_q < period_i - 1) ? cnt_q + 1 : 0;
    if (run_i && cnt_q == period_i - 1) begin
      pos_q <= rev_i ? (pos_q + 4 * PPR - 1) % (4 * PPR) : (pos_q + 1) % (4 * PPR);
    end
  end
  assign pos_o = pos_q;
  assign track_a_o = pos_q[1];
  assign track_b_o = pos_q[1] ^ pos_q[0];
  assign index_o = (pos_q < 4) && pos_q[1];
endmodule : isad_enc_model
